// ---- adhs_fifo.sv ----
// Receive buffer for host-to-device data words
`timescale 1ns/10ps
`default_nettype none

module adhs_fifo #(
	parameter int W     = 16,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic reset_i,
	// Buffer ports
	adhs_fifo_if.store f
);
	import adhs_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [CW-1:0]           cnt;
	} adhs_fifo_state_type;

	adhs_fifo_state_type q;
	adhs_fifo_state_type d;
	logic                wr;
	logic                rd;

	// Pointers wrap by width, so DEPTH must be a power of two
	always_comb begin
		d = q;
		wr = f.wvalid && (q.cnt != CW'(DEPTH));
		rd = f.rready && (q.cnt != '0);
		if (wr) begin
			d.mem[q.wp] = f.wdata;
			d.wp = q.wp + 1'b1;
		end
		if (rd) begin
			d.rp = q.rp + 1'b1;
		end
		if (wr && !rd) begin
			d.cnt = q.cnt + 1'b1;
		end else if (rd && !wr) begin
			d.cnt = q.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// Honest flags straight from the count
	assign f.wready = (q.cnt != CW'(DEPTH));
	assign f.rvalid = (q.cnt != '0);
	assign f.rdata  = q.mem[q.rp];
	assign f.count  = q.cnt;
endmodule

`default_nettype wire

// ---- adhs_fifo_if.sv ----
// Carrier between the port logic and its receive buffer
`timescale 1ns/10ps
`default_nettype none

interface adhs_fifo_if #(
	parameter int W     = 16,
	parameter int DEPTH = 8
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  wdata;
	logic          wvalid;
	logic          wready;
	logic [W-1:0]  rdata;
	logic          rvalid;
	logic          rready;
	logic [CW-1:0] count;

	modport user (
		output wdata,
		output wvalid,
		output rready,
		input  wready,
		input  rdata,
		input  rvalid,
		input  count
	);

	modport store (
		input  wdata,
		input  wvalid,
		input  rready,
		output wready,
		output rdata,
		output rvalid,
		output count
	);
endinterface

`default_nettype wire

// ---- adhs_host_model.sv ----
// Behavioural host controller driving the ATA pins
`timescale 1ns/10ps
`default_nettype none

module adhs_host_model (
	// Clock and device answers
	input wire logic clk_i,
	input wire logic iordy_i,
	input wire logic dmarq_i,
	// Host pins
	output logic rst_n_o,
	output logic [2:0] da_o,
	output logic cs0_n_o,
	output logic cs1_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic ack_n_o,
	output logic [15:0] dd_o,
	output logic dd_en_o
);
	// Idle host: strobes negated, bus released
	initial begin
		rst_n_o = 1'b1;
		da_o = 3'h0;
		cs0_n_o = 1'b1;
		cs1_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		ack_n_o = 1'b1;
		dd_o = 16'h0000;
		dd_en_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// One PIO cycle; the strobe stays down while the device stretches it
	task automatic pio(input logic wr, input logic cs1, input logic [2:0] a, input logic [15:0] d);
		@(posedge clk_i);
		cs0_n_o <= cs1;
		cs1_n_o <= !cs1;
		da_o <= a;
		dd_o <= d;
		dd_en_o <= wr;
		tick(1);
		if (wr) begin
			wr_n_o <= 1'b0;
		end else begin
			rd_n_o <= 1'b0;
		end
		tick(4);
		for (int i = 0; i < 200 && !iordy_i; i++) begin
			@(posedge clk_i);
		end
		wr_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		tick(5); // Data outlives the strobe so the synchroniser sees it
		cs0_n_o <= 1'b1;
		cs1_n_o <= 1'b1;
		dd_en_o <= 1'b0;
	endtask

	task automatic pin_reset();
		rst_n_o <= 1'b0;
		tick(8);
		rst_n_o <= 1'b1;
		tick(6);
	endtask

	// Acknowledge a request; chip selects are already negated
	task automatic start(input logic out);
		for (int i = 0; i < 200 && !dmarq_i; i++) begin
			@(posedge clk_i);
		end
		ack_n_o <= 1'b0;
		wr_n_o <= 1'b0;
		rd_n_o <= out;
		dd_en_o <= out;
		tick(4);
	endtask

	// One data-out word; the strobe waits while the device holds off
	task automatic send(input logic [15:0] w);
		dd_o <= w;
		tick(4);
		for (int i = 0; i < 400 && iordy_i; i++) begin
			@(posedge clk_i);
		end
		rd_n_o <= !rd_n_o;
		tick(4);
	endtask

	task automatic stop();
		wr_n_o <= 1'b1;
		tick(4);
		ack_n_o <= 1'b1;
		rd_n_o <= 1'b1;
		dd_en_o <= 1'b0;
		tick(2);
	endtask
endmodule

`default_nettype wire

// ---- adhs_params.svh ----
// Constants for the ATA device-side host signalling port
// Function
// RULE1: RESET- pin returns device to reset
// RULE2: Registers on low byte, data 16 bits
// RULE3: Selected device drives INTRQ when pending
// RULE4: Decode DA address to register or data
// RULE5: CS0 command block, CS1 control block
// RULE6: DMACK masks chip selects, 16-bit transfers
// RULE7: DDMARDY- gives flow control in data-out
// RULE8: DSTROBE marks each data-in word
// RULE9: IOCS16- when data port addressed, ready
// RULE10: Device 1 asserts PDIAG- after diagnostics
// RULE11: DASP- multiplexes activity and Device 1 presence
// RULE12: Host DIOR- strobes reads, device drives
// RULE13: Host DIOW- strobes writes, device captures
// RULE14: Host HDMARDY- readiness during data-in burst
// RULE15: Host HSTROBE marks data-out words
// RULE16: Host STOP ends burst, device stops
// RULE17: Host DMACK- answers DMARQ, starts transfer
// RULE18: DMARQ only when ready to transfer
// RULE19: Negated IORDY stretches the PIO cycle
// RULE20: Drive data bus only for reads, bursts
`ifndef ADHS_PARAMS_SVH
`define ADHS_PARAMS_SVH

// Pin sample vector layout
`define ADHS_PIN_W        25
`define ADHS_PIN_DD_LO    0
`define ADHS_PIN_DD_HI    15
`define ADHS_PIN_DA_LO    16
`define ADHS_PIN_DA_HI    18
`define ADHS_PIN_DMACK_N  19
`define ADHS_PIN_DIOW_N   20
`define ADHS_PIN_DIOR_N   21
`define ADHS_PIN_CS1_N    22
`define ADHS_PIN_CS0_N    23
`define ADHS_PIN_RST_N    24

// Address of the data port within the command block
`define ADHS_DATA_DA      3'h0

// Reset values
`define ADHS_WORD_RESET   16'h0000
`define ADHS_PIN_RESET    25'h1FFFFFF

// Timing
`define ADHS_CLK_PERIOD_NS 100
`define ADHS_DASP_PRES_US  1000
`define ADHS_DASP_PRES_CYCLES (`ADHS_DASP_PRES_US * 1000 / `ADHS_CLK_PERIOD_NS)

// Buffer geometry
`define ADHS_FIFO_WIDTH   16
`define ADHS_FIFO_DEPTH   8

`endif

// ---- adhs_pkg.sv ----
// Types shared by the ATA device-side host port
`include "adhs_params.svh"

package adhs_pkg;

	typedef logic [15:0] adhs_word_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_REQ,
		ST_OUT,
		ST_IN
	} adhs_dma_state_type;

	typedef struct packed {
		logic [`ADHS_PIN_W-1:0] s1;
		logic [`ADHS_PIN_W-1:0] s2;
		logic [`ADHS_PIN_W-1:0] prv;
		logic                   dev1;
		logic [15:0]            pres_cnt;
		logic                   pres;
		adhs_word_type          tx_word;
		logic                   tx_full;
		logic                   tx_rdy;
		logic                   rd_done;
		adhs_dma_state_type     st;
		logic                   dir_in;
		logic                   dphase;
		logic                   dstb;
		adhs_word_type          dd_out;
		logic                   dd_oe_n;
		logic                   pin27;
		logic                   dmarq;
		logic                   intrq;
		logic                   intrq_oe_n;
		logic                   iocs_oe_n;
		logic                   pdiag_oe_n;
		logic                   dasp_oe_n;
		logic                   reg_wr;
		logic                   reg_rd;
		logic [3:0]             reg_addr;
		logic [7:0]             reg_wdata;
		logic                   push;
		adhs_word_type          push_data;
	} adhs_state_type;

	// Reset value of the port state; released pins and idle strobes
	function automatic adhs_state_type adhs_reset_state();
		adhs_state_type r;
		r = '0;
		r.s1 = `ADHS_PIN_RESET;
		r.s2 = `ADHS_PIN_RESET;
		r.prv = `ADHS_PIN_RESET;
		r.tx_word = `ADHS_WORD_RESET;
		r.dd_out = `ADHS_WORD_RESET;
		r.push_data = `ADHS_WORD_RESET;
		r.st = ST_IDLE;
		r.dd_oe_n = 1'b1;
		r.pin27 = 1'b1;
		r.intrq_oe_n = 1'b1;
		r.iocs_oe_n = 1'b1;
		r.pdiag_oe_n = 1'b1;
		r.dasp_oe_n = 1'b1;
		r.pres = 1'b1;
		return r;
	endfunction

endpackage

// ---- adhs_port.sv ----
// Device-side ATA host port: PIO, register strobes, Ultra DMA, status pins
`timescale 1ns/10ps
`default_nettype none
`include "adhs_params.svh"

module adhs_port #(
	parameter int FIFO_DEPTH  = `ADHS_FIFO_DEPTH,
	parameter int PRES_CYCLES = `ADHS_DASP_PRES_CYCLES
) (
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	// Host pins, inputs
	input  wire logic                  reset_n_i,
	input  wire logic [2:0]            da_i,
	input  wire logic                  cs0_n_i,
	input  wire logic                  cs1_n_i,
	input  wire logic                  dior_n_i,
	input  wire logic                  diow_n_i,
	input  wire logic                  dmack_n_i,
	// Host data bus, three signals
	input  wire adhs_pkg::adhs_word_type dd_i,
	output var  adhs_pkg::adhs_word_type dd_o,
	output var  logic                  dd_oe_n_o,
	// Host pins, outputs
	output var  logic                  dmarq_o,
	output var  logic                  iordy_o,
	output var  logic                  intrq_o,
	output var  logic                  intrq_oe_n_o,
	output var  logic                  iocs16_n_o,
	output var  logic                  iocs16_oe_n_o,
	// Open-drain status pins
	input  wire logic                  pdiag_n_i,
	output var  logic                  pdiag_n_o,
	output var  logic                  pdiag_oe_n_o,
	input  wire logic                  dasp_n_i,
	output var  logic                  dasp_n_o,
	output var  logic                  dasp_oe_n_o,
	// Device status from the core
	input  wire logic                  dev1_strap_i,
	input  wire logic                  selected_i,
	input  wire logic                  irq_pending_i,
	input  wire logic                  diag_done_i,
	input  wire logic                  active_i,
	// Register access toward the core
	output var  logic                  reg_wr_o,
	output var  logic                  reg_rd_o,
	output var  logic [3:0]            reg_addr_o,
	output var  logic [7:0]            reg_wdata_o,
	input  wire logic [7:0]            reg_rdata_i,
	// Words from the core toward the host
	input  wire adhs_pkg::adhs_word_type tx_data_i,
	input  wire logic                  tx_valid_i,
	output var  logic                  tx_ready_o,
	// Words from the host toward the core
	output var  adhs_pkg::adhs_word_type rx_data_o,
	output var  logic                  rx_valid_o,
	input  wire logic                  rx_ready_i,
	// DMA request from the core
	input  wire logic                  dma_req_i,
	input  wire logic                  dma_dir_in_i
);
	import adhs_pkg::*;

	localparam int CW = $clog2(FIFO_DEPTH + 1);

	adhs_state_type         q;
	adhs_state_type         d;
	logic [`ADHS_PIN_W-1:0] pins_raw;
	logic                   dma;
	logic                   cs0;
	logic                   cs1;
	logic                   sel;
	logic                   data_port;
	logic                   rd_level;
	logic                   wr_level;
	logic                   wr_rise;
	logic                   stop;
	logic                   hstb_edge;
	logic                   room;
	adhs_word_type          dd_s;

	adhs_fifo_if #(.W(`ADHS_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) rxf ();

	// Receive buffer; its fill-side ready throttles the host by IORDY, its fill count by DDMARDY-
	adhs_fifo #(
		.W     (`ADHS_FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.f       (rxf.store)
	);

	// All host pins pass two flip-flops before use
	assign pins_raw = {reset_n_i, cs0_n_i, cs1_n_i, dior_n_i, diow_n_i, dmack_n_i, da_i, dd_i};

	// Decode from the second sync stage; edges compare it with the stage after
	always_comb begin
		dd_s      = q.s2[`ADHS_PIN_DD_HI:`ADHS_PIN_DD_LO];
		dma       = !q.s2[`ADHS_PIN_DMACK_N];
		cs0       = !q.s2[`ADHS_PIN_CS0_N] && !dma;  // Selects ignored under DMACK- [RULE6]
		cs1       = !q.s2[`ADHS_PIN_CS1_N] && !dma;  // [RULE5]
		sel       = cs0 ^ cs1;
		data_port = cs0 && !cs1 &&
			(q.s2[`ADHS_PIN_DA_HI:`ADHS_PIN_DA_LO] == `ADHS_DATA_DA);  // [RULE4]
		rd_level  = !q.s2[`ADHS_PIN_DIOR_N] && !dma;
		wr_level  = !q.s2[`ADHS_PIN_DIOW_N] && !dma;
		wr_rise   = !q.prv[`ADHS_PIN_DIOW_N] && q.s2[`ADHS_PIN_DIOW_N] && !dma;
		stop      = q.s2[`ADHS_PIN_DIOW_N];
		hstb_edge = q.s2[`ADHS_PIN_DIOR_N] != q.prv[`ADHS_PIN_DIOR_N];
		// Two words of slack cover strobes already in flight
		room      = rxf.count <= CW'(FIFO_DEPTH - 2);
	end

	// Next-state logic for the whole port
	always_comb begin
		d = q;
		d.s1 = pins_raw;
		d.s2 = q.s1;
		d.prv = q.s2;
		d.reg_wr = 1'b0;
		d.reg_rd = 1'b0;
		d.push = 1'b0;

		// Accept a word from the core into the single transmit holding register
		if (tx_valid_i && !q.tx_full) begin
			d.tx_word = tx_data_i;
			d.tx_full = 1'b1;
		end

		// PIO read: data port gives a full word, registers the low byte
		if (!rd_level) begin
			d.rd_done = 1'b0;
		end else if (sel && !q.rd_done) begin
			if (data_port) begin
				if (q.tx_full) begin
					d.dd_out = q.tx_word;  // [RULE2] [RULE12]
					d.tx_full = 1'b0;
					d.rd_done = 1'b1;
				end
			end else begin
				d.reg_rd = 1'b1;  // [RULE12]
				d.reg_addr = {cs1, q.s2[`ADHS_PIN_DA_HI:`ADHS_PIN_DA_LO]};
				d.rd_done = 1'b1;
			end
		end
		// Register data follows the core while the strobe is held
		if (rd_level && sel && !data_port) begin
			d.dd_out = {8'h00, reg_rdata_i};  // [RULE2]
		end

		// PIO write completes on the trailing edge of DIOW-
		if (wr_rise && sel) begin
			if (data_port) begin
				d.push = 1'b1;  // [RULE13]
				d.push_data = dd_s;
			end else begin
				d.reg_wr = 1'b1;  // [RULE13]
				d.reg_addr = {cs1, q.s2[`ADHS_PIN_DA_HI:`ADHS_PIN_DA_LO]};
				d.reg_wdata = dd_s[7:0];  // [RULE2]
			end
		end

		// Bus driven only inside a read strobe outside bursts
		d.dd_oe_n = !(rd_level && sel);  // [RULE20]
		// Hold IORDY low until the data port can complete the cycle
		d.pin27 = !((rd_level && data_port && !d.rd_done) ||
			(wr_level && data_port && !rxf.wready));  // [RULE19]

		// Ultra DMA sequencing
		unique case (q.st)
			ST_IDLE: begin
				d.dmarq = 1'b0;
				if (dma_req_i && (dma_dir_in_i ? q.tx_full : room)) begin
					d.dmarq = 1'b1;  // [RULE18]
					d.dir_in = dma_dir_in_i;
					d.st = ST_REQ;
				end
			end
			ST_REQ: begin
				if (!dma_req_i) begin
					d.dmarq = 1'b0;
					d.st = ST_IDLE;
				end else if (dma && !stop) begin
					// Burst starts only once the host acknowledges [RULE17]
					d.st = q.dir_in ? ST_IN : ST_OUT;
					d.dphase = 1'b0;
					// Strobe starts at the idle pin level, so entry makes no false edge
					d.dstb = 1'b1;
				end
			end
			ST_OUT: begin
				d.pin27 = !room;  // Low means ready for more [RULE7]
				if (hstb_edge) begin
					d.push = 1'b1;  // Both strobe edges carry a word [RULE15]
					d.push_data = dd_s;  // [RULE6]
				end
				if (stop || !dma) begin
					d.dmarq = 1'b0;  // [RULE16]
					d.st = ST_IDLE;
				end
			end
			ST_IN: begin
				d.dd_oe_n = 1'b0;  // [RULE20]
				if (q.dphase) begin
					// Data has stood one cycle before the strobe edge
					d.dstb = !q.dstb;  // [RULE8]
					d.dphase = 1'b0;
				end else if (q.tx_full && !q.s2[`ADHS_PIN_DIOR_N]) begin
					d.dd_out = q.tx_word;  // Only while host is ready [RULE14]
					d.tx_full = 1'b0;
					d.dphase = 1'b1;
				end
				d.pin27 = d.dstb;
				if (stop || !dma) begin
					d.dmarq = 1'b0;  // [RULE16]
					d.dd_oe_n = 1'b1;
					d.pin27 = 1'b1;
					d.st = ST_IDLE;
				end
			end
		endcase

		d.tx_rdy = !d.tx_full;

		// Only the selected device drives INTRQ
		d.intrq = irq_pending_i;  // [RULE3]
		d.intrq_oe_n = !selected_i;  // [RULE3]

		// IOCS16- only when the data port can move a word now
		d.iocs_oe_n = !(data_port && (q.tx_full || room));  // [RULE9]

		// Device 1 reports finished diagnostics
		d.pdiag_oe_n = !(q.dev1 && diag_done_i);  // [RULE10]

		// Presence window after reset, then activity
		if (q.pres) begin
			if (q.pres_cnt == 16'(PRES_CYCLES - 1)) begin
				d.pres = 1'b0;
			end else begin
				d.pres_cnt = q.pres_cnt + 16'h0001;
			end
		end
		d.dasp_oe_n = !(q.pres ? q.dev1 : active_i);  // [RULE11]

		// Host hardware reset clears everything but the synchronisers and the receive buffer
		if (!q.s2[`ADHS_PIN_RST_N]) begin
			d = adhs_reset_state();  // [RULE1]
			d.s1 = pins_raw;
			d.s2 = q.s1;
			d.prv = q.s2;
			d.dev1 = dev1_strap_i;  // Strap caught while reset holds
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= adhs_reset_state();
		end else begin
			q <= d;
		end
	end

	// Buffer connections
	assign rxf.wdata  = q.push_data;
	assign rxf.wvalid = q.push;
	assign rxf.rready = rx_ready_i;

	// Outputs from the state register; the open-drain pin levels are tied low
	assign dd_o          = q.dd_out;
	assign dd_oe_n_o     = q.dd_oe_n;
	assign dmarq_o       = q.dmarq;
	assign iordy_o       = q.pin27;
	assign intrq_o       = q.intrq;
	assign intrq_oe_n_o  = q.intrq_oe_n;
	assign iocs16_n_o    = 1'b0;
	assign iocs16_oe_n_o = q.iocs_oe_n;
	assign pdiag_n_o     = 1'b0;
	assign pdiag_oe_n_o  = q.pdiag_oe_n;
	assign dasp_n_o      = 1'b0;
	assign dasp_oe_n_o   = q.dasp_oe_n;
	assign reg_wr_o      = q.reg_wr;
	assign reg_rd_o      = q.reg_rd;
	assign reg_addr_o    = q.reg_addr;
	assign reg_wdata_o   = q.reg_wdata;
	assign tx_ready_o    = q.tx_rdy;
	// Buffer head is read straight from its storage flops
	assign rx_data_o     = rxf.rdata;
	assign rx_valid_o    = rxf.rvalid;
endmodule

`default_nettype wire

// ---- adhs_port_asserts.sv ----
// Pin-level checks for the ATA device-side host port
`timescale 1ns/10ps
`default_nettype none
`include "adhs_params.svh"

module adhs_port_asserts (
	// Clock and resets
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic reset_n_i,
	// Host pins, then the device strap and diagnostics status from the core
	input wire logic [2:0] da_i,
	input wire logic cs0_n_i,
	input wire logic cs1_n_i,
	input wire logic dior_n_i,
	input wire logic diow_n_i,
	input wire logic dmack_n_i,
	input wire adhs_pkg::adhs_word_type dd_i,
	input wire adhs_pkg::adhs_word_type dd_o,
	input wire logic dd_oe_n_o,
	input wire logic dmarq_o,
	input wire logic iordy_o,
	input wire logic intrq_o,
	input wire logic intrq_oe_n_o,
	input wire logic iocs16_oe_n_o,
	input wire logic pdiag_oe_n_o,
	input wire logic dev1_strap_i,
	input wire logic diag_done_i,
	// Core side
	input wire logic selected_i,
	input wire logic irq_pending_i,
	input wire logic dma_req_i,
	input wire logic reg_wr_o,
	input wire logic reg_rd_o,
	input wire logic [3:0] reg_addr_o,
	input wire logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);
	logic [2:0] up_q;
	logic dp;

	// Cycles since both resets let go; the pin synchronisers need a few to refill
	always_ff @(posedge clk_i) begin
		up_q <= (reset_i || !reset_n_i) ? 3'h0 : (up_q == 3'h7 ? up_q : up_q + 3'h1);
	end

	// Host is pointing at the 16-bit data port
	assign dp = da_i == `ADHS_DATA_DA && !cs0_n_i && cs1_n_i && dmack_n_i;

	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);

	a_intrq_follow: assert property (
		up_q == 3'h7 |-> intrq_o == $past(irq_pending_i) && intrq_oe_n_o == !$past(selected_i))
		else $error("interrupt pin does not follow the core");
	a_dmarq_cause: assert property ($rose(dmarq_o) |-> $past(dma_req_i))
		else $error("dma request without core request");
	a_rd_decode: assert property (
		reg_rd_o |-> !$past(dior_n_i, 2) && $past(cs0_n_i, 2) != $past(cs1_n_i, 2)
		&& reg_addr_o == {!$past(cs1_n_i, 2), $past(da_i, 2)})
		else $error("register read without a proper strobe");
	a_rd_low_byte: assert property (
		reg_rd_o |-> !dd_oe_n_o && dd_o == {8'h00, $past(reg_rdata_i)})
		else $error("register read not on the low byte");
	a_wr_capture: assert property (
		reg_wr_o |-> reg_wdata_o == $past(dd_i[7:0], 2)
		&& reg_addr_o == {!$past(cs1_n_i, 2), $past(da_i, 2)})
		else $error("register write captured wrong byte or address");
	a_bus_release: assert property (
		!dd_oe_n_o |-> !($past(dior_n_i, 2) && $past(dior_n_i, 3)
		&& $past(dior_n_i, 4) && $past(dior_n_i, 5)))
		else $error("data bus driven outside a read");
	a_burst_stop: assert property (
		$rose(diow_n_i) && !dmack_n_i |-> ##[2:5] (dd_oe_n_o && iordy_o && !dmarq_o))
		else $error("burst did not end on stop");
	a_iocs16_port: assert property (
		!iocs16_oe_n_o |-> $past(dp, 2) || $past(dp, 3) || $past(dp, 4) || $past(dp, 5))
		else $error("width pin asserted off the data port");
	a_pin_reset: assert property (
		!reset_n_i [*5] |-> dd_oe_n_o && iordy_o && !dmarq_o && !reg_wr_o)
		else $error("pin reset not honoured");
	a_pdiag_done: assert property (
		!pdiag_oe_n_o |-> dev1_strap_i && $past(diag_done_i))
		else $error("diagnostics pin asserted without finished diagnostics");
endmodule

`default_nettype wire

// ---- test_ata_device_host_signalling.sv ----
// Self-checking bench for the ATA device-side host port
`timescale 1ns/10ps
`default_nettype none

module test_ata_device_host_signalling;
	import adhs_pkg::*;
	logic clk_i = 1'b0, reset_i = 1'b1, reset_n_i;
	logic [2:0] da_i;
	logic cs0_n_i, cs1_n_i, dior_n_i, diow_n_i, dmack_n_i, h_en;
	adhs_word_type dd_i, dd_o, h_dd, tx_data_i = 16'h0000, rx_data_o;
	logic dd_oe_n_o, dmarq_o, iordy_o, intrq_o, intrq_oe_n_o, iocs16_n_o, iocs16_oe_n_o;
	logic pdiag_n_i, pdiag_n_o, pdiag_oe_n_o, dasp_n_i, dasp_n_o, dasp_oe_n_o;
	logic dev1_strap_i = 1'b1, selected_i = 1'b1, irq_pending_i = 1'b0;
	logic diag_done_i = 1'b0, active_i = 1'b0, dma_req_i = 1'b0, dma_dir_in_i = 1'b0;
	logic reg_wr_o, reg_rd_o, tx_valid_i = 1'b0, tx_ready_o, rx_valid_o, rx_ready_i = 1'b0;
	logic [3:0] reg_addr_o;
	logic [7:0] reg_wdata_o, reg_rdata_i = 8'h00;
	logic [15:0] wrq[$], rdq[$], rxq[$], inq[$];
	logic [31:0] seed, r, rr, rt;
	logic [2:0] a;
	logic cs, stb_q = 1'b1;
	int fail_count = 0, checks_done = 0, cyc = 0, i, j;

	// Wire levels: released bus shows a moving pattern, open-drain pins pull up
	assign dd_i = !dd_oe_n_o ? dd_o : (h_en ? h_dd : ~cyc[15:0]);
	assign pdiag_n_i = pdiag_oe_n_o ? 1'b1 : pdiag_n_o;
	assign dasp_n_i = dasp_oe_n_o ? 1'b1 : dasp_n_o;

	adhs_port #(.FIFO_DEPTH(8), .PRES_CYCLES(8)) u_adhs_port (.*);
	adhs_host_model u_adhs_host_model (.clk_i, .iordy_i(iordy_o), .dmarq_i(dmarq_o),
		.rst_n_o(reset_n_i), .da_o(da_i), .cs0_n_o(cs0_n_i), .cs1_n_o(cs1_n_i),
		.rd_n_o(dior_n_i), .wr_n_o(diow_n_i), .ack_n_o(dmack_n_i), .dd_o(h_dd), .dd_en_o(h_en));

	always #50 clk_i = ~clk_i;

	task automatic summarize();
		if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	// Compare a result with the oldest note of its kind
	task automatic take(ref logic [15:0] q[$], input logic [15:0] got);
		checks_done++;
		if (q.size() == 0 || got !== q[0]) begin
			fail_count++;
			$display("mismatch at %0t: got %h", $time, got);
		end
		if (q.size() != 0) void'(q.pop_front());
	endtask

	// Results as they appear; a data-in word is taken on each device strobe edge
	always @(posedge clk_i) begin
		if (reg_wr_o) take(wrq, {reg_addr_o, 4'h0, reg_wdata_o});
		if (reg_rd_o) take(rdq, dd_o);
		if (rx_valid_o && rx_ready_i) take(rxq, rx_data_o);
		if (!dmack_n_i && !dd_oe_n_o && iordy_o !== stb_q) take(inq, dd_o);
		stb_q <= iordy_o;
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fail_count++;
			summarize();
		end
	end

	// Register writes then reads over both blocks, never the data port
	task automatic regs();
		for (int k = 0; k < 4; k++) begin
			rr = $random(seed);
			cs = k[0];
			a = (!cs && rr[10:8] == 3'h0) ? 3'h7 : rr[10:8];
			wrq.push_back({cs, a, 4'h0, rr[7:0]});
			u_adhs_host_model.pio(1'b1, cs, a, rr[15:0]);
			reg_rdata_i <= rr[23:16];
			rdq.push_back({8'h00, rr[23:16]});
			u_adhs_host_model.pio(1'b0, cs, a, 16'h0000);
		end
	endtask

	initial begin
		seed = 32'ha605;
		repeat (3) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		regs();
		// Data port writes fill the buffer; the ninth waits until it drains
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			rxq.push_back(r[15:0]);
			u_adhs_host_model.pio(1'b1, 1'b0, 3'h0, r[15:0]);
		end
		r = $random(seed);
		rxq.push_back(r[15:0]);
		fork
			u_adhs_host_model.pio(1'b1, 1'b0, 3'h0, r[15:0]);
			begin
				repeat (40) @(posedge clk_i);
				rx_ready_i <= 1'b1;
			end
		join
		// Data-out burst with the core stalling so flow control kicks in
		repeat (10) @(posedge clk_i);
		rx_ready_i <= 1'b0;
		dma_req_i <= 1'b1;
		fork
			begin
				repeat (120) @(posedge clk_i);
				rx_ready_i <= 1'b1;
			end
		join_none
		u_adhs_host_model.start(1'b1);
		for (i = 0; i < 10; i++) begin
			r = $random(seed);
			rxq.push_back(r[15:0]);
			u_adhs_host_model.send(r[15:0]);
		end
		dma_req_i <= 1'b0;
		u_adhs_host_model.stop();
		// Data-in burst fed word by word from the core
		repeat (10) @(posedge clk_i);
		dma_dir_in_i <= 1'b1;
		fork
			begin
				for (j = 0; j < 4; j++) begin
					rt = $random(seed);
					inq.push_back(rt[15:0]);
					tx_data_i <= rt[15:0];
					tx_valid_i <= 1'b1;
					do @(posedge clk_i); while (!tx_ready_o);
				end
				tx_valid_i <= 1'b0;
			end
		join_none
		dma_req_i <= 1'b1;
		u_adhs_host_model.start(1'b0);
		for (i = 0; i < 400 && inq.size() != 0; i++) @(posedge clk_i);
		dma_req_i <= 1'b0;
		u_adhs_host_model.stop();
		// Core status levels wander while the interrupt pin follows
		repeat (16) begin
			@(posedge clk_i);
			r = $random(seed);
			selected_i <= r[0];
			irq_pending_i <= r[1];
			diag_done_i <= r[2];
			active_i <= r[3];
		end
		selected_i <= 1'b1;
		u_adhs_host_model.pin_reset();
		regs();
		repeat (10) @(posedge clk_i);
		if (wrq.size() + rdq.size() + rxq.size() + inq.size() != 0) fail_count++;
		summarize();
	end
endmodule

bind adhs_port adhs_port_asserts u_adhs_port_asserts (.*);

`default_nettype wire
